/* rtl/ssdr_ctrl.sv */
// register side of the sram secded unit: status, irq, debug pointer, data and command
//
// Chosen here: the plain strobed port.
`include "ssdr_regs.svh"

module ssdr_ctrl #(
  parameter int ADDR_W = 13,                    // word address bits really stored
  parameter int BASE_W = 24                     // pointer width
) (
  input wire logic core_clk,                    // system clock, 20 mhz
  input wire logic reset_n,                     // async reset, active low
  input wire logic special_mode,                // chip special mode, async pin
  input wire logic [7:0] reg_addr,              // register offset
  input wire logic [7:0] reg_wdata,             // write data
  input wire logic reg_wr,                      // write strobe
  input wire logic reg_rd,                      // read strobe
  output logic [7:0] reg_rdata,                 // read data, cycle after strobe
  output logic irq_req,                         // single error interrupt level
  output logic ready,                           // init done, access allowed
  output logic read_repair_disable,             // stop automatic read repair
  input wire logic single_err_event,            // one-cycle pulse from checker
  input wire logic sys_busy,                    // other masters pending this cycle
  output logic mem_req,                         // array strobe
  output logic mem_we,                          // array write enable
  output logic [ADDR_W-1:0] mem_addr,           // array word address
  output logic [15:0] mem_wdata,                // raw data to array
  output logic [5:0] mem_wcheck,                // raw check bits to array
  input wire logic [15:0] mem_rdata,            // raw data from array, next cycle
  input wire logic [5:0] mem_rcheck             // raw check bits from array
);
  import ssdr_pkg::*;

  // ******************************
  // reset release and pin sync
  // ******************************
  logic rst_meta_q;                             // first release stage
  logic rst_n_q;                                // released reset used below
  logic spec_meta_q;                            // special mode first stage
  logic spec_q;                                 // special mode, synchronous

  // assertion is immediate; only the release waits for the clock
  // reset deasserts cleanly on the clock
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // the mode pin may change at any time; only the synced copy is read
  // special mode is a pin: two stages before use
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      spec_meta_q <= 1'b0;
      spec_q <= 1'b0;
    end
    else
    begin
      spec_meta_q <= special_mode;
      spec_q <= spec_meta_q;
    end
  end

  // ******************************
  // register state
  // ******************************
  logic irq_en_q;                               // single_err_irq_en
  logic flag_q;                                 // single_err_flag
  logic [BASE_W-1:0] ptr_q;                     // debug_pointer
  logic [15:0] data_q;                          // debug_data_word
  logic [5:0] check_q;                          // debug_check_value
  logic wr_cmd_q;                               // debug_write_cmd
  logic rd_cmd_q;                               // debug_read_cmd
  logic repair_dis_q;                           // read_repair_disable
  ssdr_state_t state_q;                         // sequencer state
  logic [ADDR_W-1:0] fill_q;                    // init fill address
  logic rd_issue_q;                             // debug read on the array this cycle
  // array answers one cycle after the strobe, so the load waits one more
  logic rd_pend_q;                              // debug read data due this cycle
  logic wr_en;                                  // qualified write strobe
  logic dbg_done;                               // debug access completes
  logic [BASE_W-1:0] ptr_mask;                  // writable pointer bits

  // bus strobes share the core clock, so no sync stage here
  assign wr_en = reg_wr;

  // only word address bits inside the array are stored; the byte lane bit 0 is not
  function automatic logic [BASE_W-1:0] ssdr_mask(input int aw);
    logic [BASE_W-1:0] m;
    m = '0;
    for (int i = 1; i <= aw; i++)
    begin
      m[i] = 1'b1;
    end
    return m;
  endfunction

  // bit 0 picks a byte lane; debug access is always word aligned
  assign ptr_mask = ssdr_mask(ADDR_W);          // R7

  // ******************************
  // interrupt enable and flag
  // ******************************
  // enable bit; reset leaves the request masked
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_en_q <= 1'b0;
    end
    else if (wr_en && reg_addr == `SSDR_OFS_IRQ_EN)
    begin
      irq_en_q <= reg_wdata[`SSDR_BIT_IRQ_EN];
    end
  end

  // sticky flag; a new event beats a clear in the same cycle
  // a zero written to the flag leaves it alone
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      flag_q <= 1'b0;
    end
    else if (single_err_event)
    begin
      flag_q <= 1'b1;                           // R4 R19
    end
    else if (wr_en && reg_addr == `SSDR_OFS_IRQ_FLAG && reg_wdata[`SSDR_BIT_FLAG])
    begin
      flag_q <= 1'b0;                           // R5
    end
  end

  // level request straight from a flop, one cycle behind the flag
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_req <= 1'b0;
    end
    else
    begin
      irq_req <= flag_q & irq_en_q;             // R3 R21
    end
  end

  // ******************************
  // debug pointer, data, check value
  // ******************************
  // pointer bytes; bits outside the array read back as zero
  // so software can see which address it really holds
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ptr_q <= `SSDR_RST_PTR;
    end
    else if (wr_en && reg_addr == `SSDR_OFS_PTR_HIGH)
    begin
      ptr_q[23:16] <= reg_wdata & ptr_mask[23:16]; // R6 R7
    end
    else if (wr_en && reg_addr == `SSDR_OFS_PTR_MID)
    begin
      ptr_q[15:8] <= reg_wdata & ptr_mask[15:8];   // R6 R7
    end
    else if (wr_en && reg_addr == `SSDR_OFS_PTR_LOW)
    begin
      ptr_q[7:0] <= reg_wdata & ptr_mask[7:0];     // R6 R7
    end
  end

  // a finished debug read overwrites data and check; it wins over software
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      data_q <= `SSDR_RST_WORD;
      check_q <= `SSDR_RST_CHECK;
    end
    else if (rd_pend_q)
    begin
      data_q <= mem_rdata;                      // R9 R15
      check_q <= mem_rcheck;                    // R10 R15
    end
    else if (wr_en && reg_addr == `SSDR_OFS_DATA_HIGH)
    begin
      data_q[15:8] <= reg_wdata;                // R9
    end
    else if (wr_en && reg_addr == `SSDR_OFS_DATA_LOW)
    begin
      data_q[7:0] <= reg_wdata;                 // R9
    end
    else if (wr_en && reg_addr == `SSDR_OFS_CHECK)
    begin
      check_q <= reg_wdata[5:0];                // R10
    end
  end

  // ******************************
  // debug command
  // ******************************
  // command bits need special mode and an idle debug path
  // a write outside special mode is dropped as a whole
  // bit 7 follows every accepted write, even while a command runs
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_cmd_q <= 1'b0;
      rd_cmd_q <= 1'b0;
      repair_dis_q <= 1'b0;
    end
    else
    begin
      if (wr_en && reg_addr == `SSDR_OFS_COMMAND && spec_q)  // R11
      begin
        repair_dis_q <= reg_wdata[`SSDR_BIT_REPAIR_DIS];     // R12
        if (!wr_cmd_q && !rd_cmd_q)                          // R17
        begin
          if (reg_wdata[`SSDR_BIT_WR_CMD])
          begin
            wr_cmd_q <= 1'b1;                   // R13 R16
          end
          else if (reg_wdata[`SSDR_BIT_RD_CMD])
          begin
            rd_cmd_q <= 1'b1;                   // R15
          end
        end
      end
      if (dbg_done)
      begin
        wr_cmd_q <= 1'b0;                       // R14
        rd_cmd_q <= 1'b0;                       // R15
      end
    end
  end

  // the repair switch goes to the read datapath as a plain level
  assign read_repair_disable = repair_dis_q;   // R12 R19

  // ******************************
  // array sequencer: fill, then lowest priority debug
  // ******************************
  // a write ends as it is launched; a read ends when its data land
  assign dbg_done = rd_pend_q || (state_q == ssdr_dbg_go && wr_cmd_q);

  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= ssdr_init_t_fill;
      fill_q <= '0;
      ready <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= `SSDR_RST_WORD;
      mem_wcheck <= `SSDR_RST_CHECK;
      rd_issue_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      rd_issue_q <= 1'b0;
      rd_pend_q <= rd_issue_q;                  // R15
      case (state_q)
        ssdr_init_t_fill:
        begin
          // the array is owned by the fill until the last word is written
          // every word gets zero data with its matching code
          mem_req <= 1'b1;                      // R20
          mem_we <= 1'b1;
          mem_addr <= fill_q;
          mem_wdata <= `SSDR_RST_WORD;
          mem_wcheck <= `SSDR_ZERO_CHECK;       // R20
          fill_q <= fill_q + 1'b1;
          // the address wraps to zero as the sequencer leaves
          if (&fill_q)
          begin
            state_q <= ssdr_idle;
          end
        end
        ssdr_idle:
        begin
          ready <= 1'b1;                        // R1 R20
          // pending debug waits for a cycle with no other master
          if ((wr_cmd_q || rd_cmd_q) && !sys_busy && !rd_issue_q && !rd_pend_q)  // R18
          begin
            state_q <= ssdr_dbg_go;
          end
        end
        default:
        begin
          // one array access; no range check on the pointer (software's job)
          mem_req <= 1'b1;
          mem_we <= wr_cmd_q;                   // R13 R16
          mem_addr <= ptr_q[ADDR_W:1];          // R8
          mem_wdata <= data_q;                  // R13
          mem_wcheck <= check_q;                // R13
          // the read strobe goes out now; its data are loaded two edges later
          rd_issue_q <= rd_cmd_q;               // R15
          state_q <= ssdr_idle;
        end
      endcase
    end
  end

  // ******************************
  // read port, data in the cycle after the strobe
  // ******************************
  // idle cycles return zero so a stale byte never lingers
  // reads have no side effects; the flag clears only on a write
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      reg_rdata <= `SSDR_RST_BYTE;
    end
    else if (!reg_rd)
    begin
      reg_rdata <= `SSDR_RST_BYTE;
    end
    else if (reg_addr == `SSDR_OFS_STATUS)
    begin
      reg_rdata <= {7'h00, ready};              // R1 R2
    end
    else if (reg_addr == `SSDR_OFS_IRQ_EN)
    begin
      reg_rdata <= {7'h00, irq_en_q};
    end
    else if (reg_addr == `SSDR_OFS_IRQ_FLAG)
    begin
      reg_rdata <= {7'h00, flag_q};             // R5
    end
    else if (reg_addr == `SSDR_OFS_PTR_HIGH)
    begin
      reg_rdata <= ptr_q[23:16];                // R6
    end
    else if (reg_addr == `SSDR_OFS_PTR_MID)
    begin
      reg_rdata <= ptr_q[15:8];
    end
    else if (reg_addr == `SSDR_OFS_PTR_LOW)
    begin
      reg_rdata <= ptr_q[7:0];
    end
    else if (reg_addr == `SSDR_OFS_DATA_HIGH)
    begin
      reg_rdata <= data_q[15:8];
    end
    else if (reg_addr == `SSDR_OFS_DATA_LOW)
    begin
      reg_rdata <= data_q[7:0];
    end
    else if (reg_addr == `SSDR_OFS_CHECK)
    begin
      reg_rdata <= {2'b00, check_q};
    end
    else if (reg_addr == `SSDR_OFS_COMMAND)
    begin
      reg_rdata <= {repair_dis_q, 5'h00, wr_cmd_q, rd_cmd_q};  // R11
    end
    else
    begin
      reg_rdata <= `SSDR_RST_BYTE;              // reserved and unmapped read zero
    end
  end
endmodule

/* common/ssdr_regs.svh */
// register offsets, field positions, reset values and the zero-word check code for the secded debug regs
//
// Functional notes
// R1 - status bit 0 shows init done
// R2 - status register read-only, writes ignored
// R3 - irq when flag set and enable bit
// R4 - single-bit error sets sticky flag
// R5 - flag cleared by writing one
// R6 - 24-bit debug pointer read/write anytime
// R7 - pointer bits outside memory not writable
// R8 - software keeps pointer inside memory
// R9 - debug data: write source, read destination
// R10 - 6-bit check value in bits 5:0
// R11 - command writable only in special mode
// R12 - command bit 7 disables read repair
// R13 - write command stores raw data and check
// R14 - write command self-clears when done
// R15 - read command loads raw data, check
// R16 - both commands set: only write runs
// R17 - no new command while one busy
// R18 - debug access lowest priority, after init
// R19 - repair disabled: flag set, word unchanged
// R20 - power-up fills memory with zero code
// R21 - irq output is flag and enable
`ifndef SSDR_REGS_SVH
`define SSDR_REGS_SVH

// ******************************
// register offsets
// ******************************
`define SSDR_OFS_STATUS 8'h00
`define SSDR_OFS_IRQ_EN 8'h01
`define SSDR_OFS_IRQ_FLAG 8'h02
`define SSDR_OFS_PTR_HIGH 8'h07
`define SSDR_OFS_PTR_MID 8'h08
`define SSDR_OFS_PTR_LOW 8'h09
`define SSDR_OFS_DATA_HIGH 8'h0c
`define SSDR_OFS_DATA_LOW 8'h0d
`define SSDR_OFS_CHECK 8'h0e
`define SSDR_OFS_COMMAND 8'h0f

// ******************************
// field positions and reset values
// ******************************
`define SSDR_BIT_READY 0
`define SSDR_BIT_IRQ_EN 0
`define SSDR_BIT_FLAG 0
`define SSDR_BIT_RD_CMD 0
`define SSDR_BIT_WR_CMD 1
`define SSDR_BIT_REPAIR_DIS 7
`define SSDR_RST_BYTE 8'h00
`define SSDR_RST_PTR 24'h000000
`define SSDR_RST_WORD 16'h0000
`define SSDR_RST_CHECK 6'h00

// ******************************
// check code of an all-zero word: every equation inverts an even parity
// ******************************
`define SSDR_ZERO_CHECK 6'h3f

`endif

/* common/ssdr_pkg.sv */
// types shared by the secded debug register block
package ssdr_pkg;
  // memory-side sequencer states
  typedef enum logic [1:0] {
    ssdr_init_t_fill,
    ssdr_idle,
    ssdr_dbg_go
  } ssdr_state_t;
  // bus access kind seen by the array port
  typedef enum logic [1:0] {
    ssdr_op_none,
    ssdr_op_read,
    ssdr_op_write
  } ssdr_op_t;
endpackage

/* verif/ssdr_ctrl_monitor.sv */
// port-level assertions for the secded debug register block
module ssdr_ctrl_monitor #(
  parameter int ADDR_W = 13 // stored word address bits
) (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset, low
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic irq_req, // irq level
  input wire logic ready, // init done
  input wire logic read_repair_disable, // repair off
  input wire logic single_err_event, // error pulse
  input wire logic mem_req, // array strobe
  input wire logic mem_we, // array write
  input wire logic [15:0] mem_wdata, // array data
  input wire logic [5:0] mem_wcheck // array check
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // clocking
  // ****************
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // ****************
  // checks
  // ****************
  a_ready_stays: assert property (ready |=> ready)
    else $error("ready fell");
  // fill is the only array traffic before ready, zero word with its code
  a_fill_zero: assert property (mem_req && !ready |->
    mem_we && mem_wdata == 16'h0000 && mem_wcheck == 6'h3f)
    else $error("fill word wrong");
  a_irq_cause: assert property ($rose(irq_req) |->
    $past(single_err_event, 2) || $past(reg_wr && reg_addr == 8'h01, 2))
    else $error("irq rose without cause");
  a_irq_cleared: assert property ($past(reg_wr && reg_addr == 8'h02 &&
    reg_wdata[0] && !single_err_event, 2) |-> !irq_req)
    else $error("irq held after clear");
  a_status_read: assert property ($past(reg_rd && reg_addr == 8'h00) |->
    reg_rdata == {7'h00, $past(ready)})
    else $error("status read wrong");
  a_repair_bit: assert property ($changed(read_repair_disable) |->
    $past(reg_wr && reg_addr == 8'h0f) && $past(reg_wdata[7]) == read_repair_disable)
    else $error("repair bit moved");
  a_one_access: assert property (ready && mem_req |=> !mem_req)
    else $error("debug access repeated");
  a_cmd_reserved: assert property ($past(reg_rd && reg_addr == 8'h0f) |->
    reg_rdata[6:2] == 5'h00)
    else $error("command reserved bits set");
endmodule

/* verif/ssdr_sram_model.sv */
// behavioural sram array at the far side of the debug path
module ssdr_sram_model #(
  parameter int ADDR_W = 13 // word address bits
) (
  input wire logic core_clk, // clock
  input wire logic mem_req, // strobe
  input wire logic mem_we, // write enable
  input wire logic [ADDR_W-1:0] mem_addr, // word address
  input wire logic [15:0] mem_wdata, // data in
  input wire logic [5:0] mem_wcheck, // check in
  output logic [15:0] mem_rdata, // data out
  output logic [5:0] mem_rcheck // check out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem_data [2**ADDR_W]; // stored words
  logic [5:0] mem_check [2**ADDR_W]; // stored codes
  initial mem_rdata = 16'h0000;
  initial mem_rcheck = 6'h00;
  // read data stand one cycle only; later it toggles so stale use shows
  always @(posedge core_clk)
  begin
    if (mem_req && mem_we)
    begin
      mem_data[mem_addr] <= mem_wdata;
      mem_check[mem_addr] <= mem_wcheck;
    end
    if (mem_req && !mem_we)
    begin
      mem_rdata <= mem_data[mem_addr];
      mem_rcheck <= mem_check[mem_addr];
    end
    else
    begin
      mem_rdata <= ~mem_rdata;
      mem_rcheck <= ~mem_rcheck;
    end
  end
endmodule

/* verif/ssdr_ctrl_tb.sv */
// self-checking bench for the secded debug register block
module ssdr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 4; // small array keeps fill short
  logic core_clk = 1'b0; // 20 mhz
  logic reset_n = 1'b0; // reset, low
  logic special_mode = 1'b0; // mode pin
  logic [7:0] reg_addr = 8'h00; // offset
  logic [7:0] reg_wdata = 8'h00; // write data
  logic reg_wr = 1'b0; // write strobe
  logic reg_rd = 1'b0; // read strobe
  logic single_err_event = 1'b0; // error pulse
  logic sys_busy = 1'b0; // other masters
  logic [7:0] reg_rdata;
  logic irq_req;
  logic ready;
  logic read_repair_disable;
  logic mem_req;
  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic [5:0] mem_wcheck;
  logic [5:0] mem_rcheck;
  int n_mismatch = 0; // mismatches
  int checks_done = 0; // comparisons
  int n_acc = 0; // array accesses after init
  int acc; // snapshot
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (mem_req && ready)
      n_acc++;
  ssdr_ctrl #(.ADDR_W(AW)) u_ssdr_ctrl (.core_clk, .reset_n, .special_mode, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_req, .ready, .read_repair_disable,
    .single_err_event, .sys_busy, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_wcheck,
    .mem_rdata, .mem_rcheck);
  ssdr_sram_model #(.ADDR_W(AW)) u_ssdr_sram_model (.core_clk, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_wcheck, .mem_rdata, .mem_rcheck);
  // ****************
  // tasks
  // ****************
  task automatic cmp(input string s, input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    cmp($sformatf("reg %h", a), reg_rdata, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial
  begin
    #200000;
    n_mismatch++;
    results();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    wt(1);
    chk(8'h00, 8'h00);
    chk(8'h01, 8'h00);
    wt(20);
    cmp("ready", ready, 1'b1);
    chk(8'h00, 8'h01);
    wr(8'h00, 8'hff);
    chk(8'h00, 8'h01);
    chk(8'h03, 8'h00);
    wr(8'h07, 8'hff);
    wr(8'h08, 8'hff);
    wr(8'h09, 8'hff);
    chk(8'h07, 8'h00);
    chk(8'h08, 8'h00);
    chk(8'h09, 8'h1e);
    // flag and irq: set, mask, ignore zero write, clear
    @(posedge core_clk);
    single_err_event <= 1'b1;
    @(posedge core_clk);
    single_err_event <= 1'b0;
    wt(2);
    cmp("irq", irq_req, 1'b0);
    chk(8'h02, 8'h01);
    wr(8'h01, 8'h01);
    wt(2);
    cmp("irq", irq_req, 1'b1);
    wr(8'h02, 8'h00);
    chk(8'h02, 8'h01);
    wr(8'h02, 8'h01);
    chk(8'h02, 8'h00);
    cmp("irq", irq_req, 1'b0);
    // command refused outside special mode
    wr(8'h0f, 8'h02);
    special_mode <= 1'b1;
    chk(8'h0f, 8'h00);
    wt(3);
    wr(8'h0c, 8'ha5);
    wr(8'h0d, 8'h3c);
    wr(8'h0e, 8'hd5);
    chk(8'h0e, 8'h15);
    wr(8'h09, 8'h06);
    wr(8'h0f, 8'h02);
    wt(4);
    chk(8'h0f, 8'h00);
    cmp("word", u_ssdr_sram_model.mem_data[3], 16'ha53c);
    cmp("code", u_ssdr_sram_model.mem_check[3], 6'h15);
    // debug read of a filled word
    wr(8'h09, 8'h02);
    wr(8'h0f, 8'h01);
    wt(5);
    chk(8'h0f, 8'h00);
    chk(8'h0c, 8'h00);
    chk(8'h0d, 8'h00);
    chk(8'h0e, 8'h3f);
    // both bits: one write access only
    wr(8'h09, 8'h0a);
    wr(8'h0c, 8'h12);
    acc = n_acc;
    wr(8'h0f, 8'h03);
    wt(5);
    cmp("accesses", n_acc - acc, 16'h1);
    cmp("word", u_ssdr_sram_model.mem_data[5], 16'h1200);
    wr(8'h0c, 8'hee);
    wr(8'h0e, 8'h01);
    // busy masters defer the access; second command refused
    @(posedge core_clk);
    sys_busy <= 1'b1;
    acc = n_acc;
    wr(8'h0f, 8'h01);
    wr(8'h0f, 8'h02);
    wt(6);
    chk(8'h0f, 8'h01);
    cmp("accesses", n_acc - acc, 16'h0);
    @(posedge core_clk);
    sys_busy <= 1'b0;
    wt(6);
    chk(8'h0f, 8'h00);
    cmp("accesses", n_acc - acc, 16'h1);
    chk(8'h0c, 8'h12);
    chk(8'h0e, 8'h3f);
    wr(8'h0f, 8'h80);
    chk(8'h0f, 8'h80);
    cmp("repair", read_repair_disable, 1'b1);
    wr(8'h0f, 8'h00);
    wt(1);
    cmp("repair", read_repair_disable, 1'b0);
    results();
  end
endmodule
bind ssdr_ctrl ssdr_ctrl_monitor #(.ADDR_W(ADDR_W)) u_ssdr_ctrl_monitor (.core_clk,
  .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_req, .ready,
  .read_repair_disable, .single_err_event, .mem_req, .mem_we, .mem_wdata, .mem_wcheck);
